// ### logic/lbr_bus_ctrl.sv
// Local bus cycle controller: bus states, write data drive, hold handover,
// exclusive-access signalling and instruction prefetch issue.
// Assumes the ready line is already synchronous to sys_clk and that the core
// presents requests and queue pops on sys_clk.
//
// Functional notes
// - Bus cycle ends on the same clock edge the shared ready line is seen.
// - Write data is driven only from phase 2 of the status state.
// - Write data stays valid one system clock after the last command state.
// - After a write, float data in phase 2 following last command; not write-write.
// - I/O cycles use exactly the memory cycle state sequence and timing.
// - Hold during a write: finish it, one idle state, then hold and grant.
// - Exclusive access asserted for acknowledge, exchange, descriptor and locked cycles.
// - Locked series: drops at end of first command of next-to-last cycle.
// - Acknowledge cycles: exclusive access drops at end of each first command.
// - Prefetch only when bus otherwise idle and two queue bytes free.
// - Control transfer to odd address starts with a single byte fetch.
// - Prefetch stops once a control transfer or halt is decoded.
// - Real mode may overshoot up to six bytes past the last transfer.
// - Protected mode prefetch stops at the last segment word; overrun raises 13.
// - Even segment end fetches a word, drops the extra byte, 13 on execution.
// - The system clock is divided by two into processor clock phases.
// - Each bus state lasts one processor clock; command repeats without ready.
// - In hold, address, data and status drivers are floated.
module lbr_bus_ctrl (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic ready_n,
   input wire logic hold_req_pin,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   output lbr_pkg::lbr_pins_t pins_out,
   output logic pins_oe,
   output logic lock_n,
   output logic bus_grant_out,
   input wire logic req_valid,
   input lbr_pkg::lbr_req_t req_in,
   output logic req_taken,
   output logic done,
   output logic [15:0] rdata,
   input wire logic xfer_valid,
   input wire logic [23:0] xfer_target,
   input wire logic stop_decoded,
   input wire logic prot_mode,
   input wire logic [23:0] code_limit,
   input wire logic [1:0] q_pop,
   input wire logic exec_valid,
   input wire logic [23:0] exec_addr,
   output logic fill_valid,
   output logic [15:0] fill_data,
   output logic [1:0] fill_bytes,
   output logic [2:0] queue_level,
   output logic exc13
);

   // ==========================================================
   // State and phase
   // ==========================================================
   lbr_pkg::lbr_state_t st_q;
   lbr_pkg::lbr_state_t st_d;
   lbr_pkg::lbr_req_t cur_q;
   lbr_pkg::lbr_req_t cur_d;
   lbr_pkg::lbr_req_t pf_req;
   logic ph_q;
   logic first_tc_q;
   logic series_q;
   logic tail_q;
   logic stop_q;
   logic stale_q;
   logic [23:0] ptr_q;
   logic [1:0] pf_cnt_q;
   logic [1:0] pf_cnt_d;
   logic hold_s;

   lbr_sync2 #(.WIDTH(1)) u_hold_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .async_in(hold_req_pin),
      .sync_out(hold_s)
   );

   // Bus state moves only at the end of phase 2
   wire end_ph = clk_en & ph_q;
   wire in_cmd = (st_q == lbr_pkg::LBR_CMD);
   wire cyc_end = end_ph & in_cmd & ~ready_n;
   // Locked series and acknowledge pairs keep the bus from the other master
   wire hold_ok = hold_s & ~series_q;
   wire pf_busy = cur_q.prefetch & (in_cmd | (st_q == lbr_pkg::LBR_STATUS));

   // ==========================================================
   // Prefetch issue
   // ==========================================================
   wire [3:0] lvl_eff = {1'b0, queue_level} + {2'b00, pf_busy ? pf_cnt_q : 2'b00};
   wire q_room = (lvl_eff <= (lbr_pkg::LBR_Q_BYTES - lbr_pkg::LBR_Q_ROOM));
   // Protected mode never runs past the last physical word of the segment
   wire seg_ok = ~prot_mode | (ptr_q[23:1] <= code_limit[23:1]);
   // Queue depth bounds real-mode overshoot to six bytes past the stop point
   wire pf_go = ~stop_q & ~xfer_valid & ~series_q & q_room & seg_ok;
   wire odd_ptr = ptr_q[0];
   // Even segment end: the upper byte of the word is read but not counted
   wire drop_hi = prot_mode & ~code_limit[0] & (ptr_q[23:1] == code_limit[23:1]);
   wire have_req = req_valid | pf_go;

   always_comb
   begin
      pf_req = lbr_pkg::LBR_REQ_RESET;
      pf_req.prefetch = 1'b1;
      pf_req.addr = ptr_q;
      pf_req.byte_op = odd_ptr;
   end

   // ==========================================================
   // Bus state machine
   // ==========================================================
   lbr_pkg::lbr_state_t st_free;
   assign st_free = hold_ok ? lbr_pkg::LBR_HOLD :
                    (have_req ? lbr_pkg::LBR_STATUS : lbr_pkg::LBR_IDLE);

   always_comb
   begin
      st_d = st_q;
      if (end_ph)
      begin
         unique case (st_q)
            lbr_pkg::LBR_IDLE: st_d = st_free;
            lbr_pkg::LBR_STATUS: st_d = lbr_pkg::LBR_CMD;
            lbr_pkg::LBR_CMD:
            begin
               if (!ready_n)
               begin
                  // Write hold time needs one idle state before handover
                  if (hold_ok && cur_q.write)
                     st_d = lbr_pkg::LBR_IDLE;
                  else
                     st_d = st_free;
               end
            end
            lbr_pkg::LBR_HOLD: st_d = hold_s ? lbr_pkg::LBR_HOLD : lbr_pkg::LBR_IDLE;
         endcase
      end
   end

   wire take = end_ph & (st_d == lbr_pkg::LBR_STATUS);
   wire take_core = take & req_valid;
   wire take_pf = take & ~req_valid;
   assign cur_d = take ? (req_valid ? req_in : pf_req) : cur_q;
   assign pf_cnt_d = (odd_ptr | drop_hi) ? 2'h1 : 2'h2;

   // Exclusive access: latched at status, dropped at end of first command of acknowledge and next-to-last locked cycles
   wire lock_now = ~lock_n;
   wire lock_drop = end_ph & first_tc_q & (cur_q.interrupt_ack_cycle | cur_q.lock_penult);
   wire lock_d = take ? (cur_d.locked | cur_d.interrupt_ack_cycle) : (lock_drop ? 1'b0 : lock_now);

   // ==========================================================
   // Pin values for the coming phase
   // ==========================================================
   wire ph_d = ~ph_q;
   wire wr_tail = cyc_end & cur_q.write;
   wire st_wr = (st_d == lbr_pkg::LBR_STATUS) & cur_d.write;
   wire cmd_wr = (st_d == lbr_pkg::LBR_CMD) & cur_d.write;
   // Late drive in status leaves time for old read drivers to turn off
   wire data_oe_d = (st_wr & ph_d) | cmd_wr | (wr_tail & ~ph_d);
   wire load_wr = st_wr & ph_d & clk_en;
   wire [1:0] sts_code = cur_d.interrupt_ack_cycle ? lbr_pkg::LBR_STS_ACK :
                         (cur_d.write ? lbr_pkg::LBR_STS_WRITE : lbr_pkg::LBR_STS_READ);
   lbr_pkg::lbr_pins_t pins_d;

   always_comb
   begin
      pins_d.status_n = (st_d == lbr_pkg::LBR_STATUS) ? sts_code : lbr_pkg::LBR_STS_NONE;
      pins_d.m_io = ~cur_d.io;
      pins_d.code_ack = ~cur_d.interrupt_ack_cycle;
      pins_d.bhe_n = cur_d.byte_op & ~cur_d.addr[0];
      pins_d.addr = cur_d.addr;
   end

   // ==========================================================
   // Queue level
   // ==========================================================
   wire fill_ev = cyc_end & cur_q.prefetch & ~stale_q & ~xfer_valid;
   wire [3:0] lvl_add = {1'b0, queue_level} + {2'b00, fill_ev ? pf_cnt_q : 2'b00};
   wire [3:0] lvl_sub = lvl_add - {2'b00, q_pop};
   wire [2:0] level_d = xfer_valid ? lbr_pkg::LBR_Q_RESET : lvl_sub[2:0];
   wire [23:0] ptr_next = ptr_q + {22'h000000, odd_ptr ? 2'h1 : 2'h2};

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         st_q <= lbr_pkg::LBR_IDLE;
         ph_q <= 1'b0;
         cur_q <= lbr_pkg::LBR_REQ_RESET;
         first_tc_q <= 1'b0;
         series_q <= 1'b0;
         tail_q <= 1'b0;
         pf_cnt_q <= 2'h0;
      end
      else if (clk_en)
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         cur_q <= cur_d;
         first_tc_q <= end_ph ? (st_q == lbr_pkg::LBR_STATUS) : first_tc_q;
         series_q <= take ? (take_core & (req_in.locked | req_in.interrupt_ack_cycle)) : series_q;
         tail_q <= wr_tail;
         pf_cnt_q <= take_pf ? pf_cnt_d : pf_cnt_q;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         ptr_q <= lbr_pkg::LBR_ADDR_RESET;
         stop_q <= 1'b0;
         stale_q <= 1'b0;
         queue_level <= lbr_pkg::LBR_Q_RESET;
      end
      else if (clk_en)
      begin
         // A stop decoded alongside a redirect still holds off the new stream
         ptr_q <= xfer_valid ? xfer_target : (take_pf ? ptr_next : ptr_q);
         stop_q <= stop_decoded | (stop_q & ~xfer_valid);
         stale_q <= (xfer_valid & pf_busy) | (stale_q & ~take);
         queue_level <= level_d;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         pins_out <= lbr_pkg::LBR_PINS_RESET;
         pins_oe <= 1'b0;
         data_out <= lbr_pkg::LBR_DATA_RESET;
         data_oe <= 1'b0;
         lock_n <= 1'b1;
         bus_grant_out <= 1'b0;
      end
      else if (clk_en)
      begin
         pins_out <= pins_d;
         pins_oe <= (st_d != lbr_pkg::LBR_HOLD);
         data_out <= load_wr ? cur_d.wdata : data_out;
         data_oe <= data_oe_d & (st_d != lbr_pkg::LBR_HOLD);
         lock_n <= ~lock_d;
         bus_grant_out <= (st_d == lbr_pkg::LBR_HOLD);
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         req_taken <= 1'b0;
         done <= 1'b0;
         rdata <= lbr_pkg::LBR_DATA_RESET;
         fill_valid <= 1'b0;
         fill_data <= lbr_pkg::LBR_DATA_RESET;
         fill_bytes <= 2'h0;
         exc13 <= 1'b0;
      end
      else if (clk_en)
      begin
         req_taken <= take_core;
         done <= cyc_end & ~cur_q.prefetch;
         rdata <= (cyc_end & ~cur_q.write) ? data_in : rdata;
         fill_valid <= fill_ev;
         fill_data <= fill_ev ? data_in : fill_data;
         fill_bytes <= fill_ev ? pf_cnt_q : fill_bytes;
         exc13 <= prot_mode & exec_valid & (exec_addr > code_limit);
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   AST_PHASE_TOGGLE: assert property (clk_en |=> ph_q != $past(ph_q))
      else $error("phase did not alternate");
   AST_STATE_HELD_PH1: assert property ((clk_en && !ph_q) |=> st_q == $past(st_q))
      else $error("bus state changed mid processor clock");
   AST_STATUS_ONE: assert property ((clk_en && ph_q && st_q == lbr_pkg::LBR_STATUS)
      |=> st_q == lbr_pkg::LBR_CMD)
      else $error("status state not followed by command");
   AST_WAIT_REPEAT: assert property ((clk_en && ph_q && in_cmd && ready_n)
      |=> in_cmd && !done)
      else $error("command ended without ready");
   AST_DONE_READY: assert property ((clk_en && ph_q && in_cmd && !ready_n && !cur_q.prefetch)
      |=> done)
      else $error("ready seen but cycle not ended");
   AST_WR_NOT_EARLY: assert property ((st_q == lbr_pkg::LBR_STATUS && !ph_q)
      |-> data_oe == tail_q)
      else $error("write data driven in status phase 1");
   AST_WR_HOLD_ONE: assert property (tail_q |-> data_oe && $stable(data_out))
      else $error("write data not held after last command");
   AST_FLOAT_AFTER: assert property ((tail_q && clk_en && !(st_q == lbr_pkg::LBR_STATUS
      && cur_q.write)) |=> !data_oe)
      else $error("data bus not floated after write");
   AST_HOLD_AFTER_WR: assert property ((clk_en && ph_q && in_cmd && !ready_n && cur_q.write
      && hold_ok) |=> st_q == lbr_pkg::LBR_IDLE && !bus_grant_out)
      else $error("no idle state before hold after write");
   AST_HOLD_FLOAT: assert property (bus_grant_out |-> !pins_oe && !data_oe
      && st_q == lbr_pkg::LBR_HOLD)
      else $error("drivers active during hold");
   AST_LOCK_DROP: assert property ((clk_en && ph_q && first_tc_q && ready_n
      && (cur_q.interrupt_ack_cycle || cur_q.lock_penult)) |=> lock_n)
      else $error("exclusive access not dropped after first command");
   AST_LOCK_SET: assert property ((take && (cur_d.locked || cur_d.interrupt_ack_cycle)) |=> !lock_n)
      else $error("exclusive access not asserted");
   AST_PF_STOP: assert property (stop_q |-> !take_pf)
      else $error("prefetch issued after stop");
   AST_PF_LIMIT: assert property ((take_pf && prot_mode)
      |=> cur_q.addr[23:1] <= code_limit[23:1])
      else $error("prefetch past segment end");
   AST_PF_ODD: assert property ((take_pf && odd_ptr) |=> cur_q.byte_op && pf_cnt_q == 2'h1)
      else $error("odd prefetch not a byte fetch");
   AST_EXC13: assert property ((clk_en && prot_mode && exec_valid && exec_addr > code_limit)
      |=> exc13)
      else $error("execution past segment not flagged");

endmodule // lbr_bus_ctrl

// ### logic/lbr_pkg.sv
// Shared constants and types of the local bus cycle controller.
// Assumes one 100 MHz system clock; everything here is a pure definition.
package lbr_pkg;

   // ==========================================================
   // Clocking
   // ==========================================================
   localparam int LBR_SYS_CLK_MHZ = 100;
   localparam int LBR_PHASES_PER_PCLK = 2;

   // ==========================================================
   // Bus states, one processor clock each
   // ==========================================================
   typedef enum logic [3:0]
   {
      LBR_IDLE = 4'b0001,
      LBR_STATUS = 4'b0010,
      LBR_CMD = 4'b0100,
      LBR_HOLD = 4'b1000
   } lbr_state_t;

   // ==========================================================
   // Status pin codes, active low
   // ==========================================================
   localparam logic [1:0] LBR_STS_NONE = 2'h3;
   localparam logic [1:0] LBR_STS_READ = 2'h1;
   localparam logic [1:0] LBR_STS_WRITE = 2'h2;
   localparam logic [1:0] LBR_STS_ACK = 2'h0;

   // ==========================================================
   // Prefetch queue
   // ==========================================================
   localparam logic [3:0] LBR_Q_BYTES = 4'h6;
   localparam logic [3:0] LBR_Q_ROOM = 4'h2;
   localparam logic [2:0] LBR_Q_RESET = 3'h0;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [23:0] LBR_ADDR_RESET = 24'h000000;
   localparam logic [15:0] LBR_DATA_RESET = 16'h0000;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic write;
      logic io;
      logic interrupt_ack_cycle;
      logic locked;
      logic lock_penult;
      logic byte_op;
      logic prefetch;
      logic [23:0] addr;
      logic [15:0] wdata;
   } lbr_req_t;

   typedef struct packed {
      logic [1:0] status_n;
      logic m_io;
      logic code_ack;
      logic bhe_n;
      logic [23:0] addr;
   } lbr_pins_t;

   localparam lbr_req_t LBR_REQ_RESET = '{
      write: 1'b0, io: 1'b0, interrupt_ack_cycle: 1'b0, locked: 1'b0, lock_penult: 1'b0,
      byte_op: 1'b0, prefetch: 1'b0, addr: LBR_ADDR_RESET, wdata: LBR_DATA_RESET};

   localparam lbr_pins_t LBR_PINS_RESET = '{
      status_n: LBR_STS_NONE, m_io: 1'b1, code_ack: 1'b1, bhe_n: 1'b1,
      addr: LBR_ADDR_RESET};

endpackage : lbr_pkg

// ### logic/lbr_sync2.sv
// Two flip-flop synchroniser for levels arriving from outside sys_clk.
// Assumes the source holds each level for at least two enabled clocks.
module lbr_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else if (clk_en)
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // lbr_sync2

// ### sim/lbr_ready_gen.sv
// Far-side model: ready synchroniser plus a memory answering each bus cycle.
// Assumes the design's status pins and the ready line share sys_clk.
module lbr_ready_gen (
   input wire logic sys_clk,
   input wire logic reset,
   input lbr_pkg::lbr_pins_t pins_out,
   input wire logic pins_oe,
   input wire logic [1:0] waits,
   input wire logic sync_ready_select_n,
   input wire logic async_ready_select_n,
   output logic ready_n,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Cycle tracking
   logic busy;
   logic transceiver_direction;
   logic [4:0] n;
   logic [23:0] a;
   wire st_on = pins_oe && (pins_out.status_n != lbr_pkg::LBR_STS_NONE);
   // Async path costs one more processor clock to resolve, never zero waits
   wire async_sel = sync_ready_select_n & ~async_ready_select_n;
   wire [2:0] w_eff = {1'b0, waits} + {2'b00, async_sel};
   wire [4:0] last = 5'h2 + {1'b0, w_eff, 1'b0};
   always @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         busy <= 1'b0;
         transceiver_direction <= 1'b1;
         n <= 5'h00;
         a <= 24'h000000;
         ready_n <= 1'b1;
         data_in <= 16'h0000;
      end
      else
      begin
         // A released data line must not keep its last value
         data_in <= ~data_in;
         n <= n + 5'h01;
         if (!busy && st_on)
         begin
            busy <= 1'b1;
            n <= 5'h01;
            a <= pins_out.addr;
            transceiver_direction <= pins_out.status_n == lbr_pkg::LBR_STS_WRITE;
         end
         else if (!ready_n)
         begin
            ready_n <= 1'b1;
            busy <= 1'b0;
            transceiver_direction <= 1'b1;
         end
         else if (busy && n == last)
         begin
            ready_n <= 1'b0;
            if (!transceiver_direction)
               data_in <= a[15:0] ^ 16'h5A3C;
         end
      end
   end
endmodule // lbr_ready_gen

// ### sim/lbr_tb.sv
// Self-checking bench for the local bus cycle controller.
// Assumes lbr_ready_gen answers every cycle from a fixed memory pattern.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset, clk_en, ready_n, hold_req_pin, data_oe, pins_oe, lock_n;
   logic bus_grant_out, req_valid, req_taken, done, xfer_valid, stop_decoded, prot_mode;
   logic exec_valid, fill_valid, exc13, sync_ready_select_n, async_ready_select_n;
   logic [15:0] data_in, data_out, rdata, fill_data;
   logic [23:0] xfer_target, code_limit, exec_addr, exp_ptr;
   logic [1:0] q_pop, fill_bytes, waits;
   logic [2:0] queue_level;
   lbr_pkg::lbr_pins_t pins_out;
   lbr_pkg::lbr_req_t req_in;
   int num_errors, cmp_count, cyc, i;
   lbr_bus_ctrl u_dut (.sys_clk, .reset, .clk_en, .ready_n, .hold_req_pin, .data_in,
      .data_out, .data_oe, .pins_out, .pins_oe, .lock_n, .bus_grant_out, .req_valid,
      .req_in, .req_taken, .done, .rdata, .xfer_valid, .xfer_target, .stop_decoded,
      .prot_mode, .code_limit, .q_pop, .exec_valid, .exec_addr, .fill_valid, .fill_data,
      .fill_bytes, .queue_level, .exc13);
   lbr_ready_gen u_far (.sys_clk, .reset, .pins_out, .pins_oe, .waits,
      .sync_ready_select_n, .async_ready_select_n, .ready_n, .data_in);
   // ==========================================================
   // Checking and closing
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         num_errors++;
         close_out();
      end
   end
   // Prefetch model: pointer walks bytes, odd start and even segment end give 1 byte
   always @(negedge sys_clk)
   begin
      if (fill_valid === 1'b1)
      begin
         check(24'(prot_mode && exp_ptr > code_limit), 24'h0);
         if (exp_ptr[0] || (prot_mode && exp_ptr == code_limit))
            check(24'(fill_bytes), 24'h1);
         else
            check(24'({fill_bytes, fill_data}), 24'({2'h2, exp_ptr[15:0] ^ 16'h5A3C}));
         exp_ptr = exp_ptr + (exp_ptr[0] ? 24'h1 : 24'h2);
      end
   end
   // ==========================================================
   // One core bus cycle, checked against the state sequence
   task automatic do_op(input logic wr, io, ia, lk, pen, input logic [1:0] w, input logic asy);
      lbr_pkg::lbr_req_t r;
      int k;
      int weff;
      r = lbr_pkg::LBR_REQ_RESET;
      r.write = wr;
      r.io = io;
      r.interrupt_ack_cycle = ia;
      r.locked = lk;
      r.lock_penult = pen;
      r.addr = {8'h00, 15'($urandom), 1'b0};
      r.wdata = 16'($urandom);
      weff = int'(w) + int'(asy);
      @(negedge sys_clk);
      waits = w;
      sync_ready_select_n = asy;
      async_ready_select_n = ~asy;
      req_in = r;
      req_valid = 1'b1;
      k = 0;
      while (req_taken !== 1'b1 && k < 50)
      begin
         @(negedge sys_clk);
         k++;
      end
      req_valid = 1'b0;
      check(24'(pins_out.status_n), wr ? 24'(lbr_pkg::LBR_STS_WRITE) :
         ia ? 24'(lbr_pkg::LBR_STS_ACK) : 24'(lbr_pkg::LBR_STS_READ));
      check(pins_out.addr, r.addr);
      check(24'({pins_out.m_io, pins_out.code_ack, pins_out.bhe_n}),
         24'({!io, !ia, 1'b0}));
      check(24'(data_oe), 24'h0);
      k = 0;
      while (done !== 1'b1 && k < 40)
      begin
         @(negedge sys_clk);
         k++;
         if (k == 1)
            check(24'({data_oe, data_out & {16{wr}}}), 24'({wr, r.wdata & {16{wr}}}));
         if (k == 2)
            check(24'(lock_n), 24'(!(lk || ia)));
         if (k == 4)
            check(24'(lock_n), 24'(!lk || pen || ia));
         if (wr && k == 4 + 2 * weff)
            check(24'({data_oe, data_out}), 24'({1'b1, r.wdata}));
      end
      check(24'(k), 24'(4 + 2 * weff));
      if (!wr)
         check(24'(rdata), 24'(r.addr[15:0] ^ 16'h5A3C));
      // Write data is held one system clock past the last command, then released
      @(negedge sys_clk);
      check(24'(data_oe), 24'h0);
   endtask
   task automatic wait_check_level(input logic [2:0] lvl);
      repeat (40) @(negedge sys_clk);
      check(24'(queue_level), 24'(lvl));
   endtask
   task automatic pop2(input int times);
      repeat (times)
      begin
         @(negedge sys_clk);
         q_pop = 2'h2;
      end
      @(negedge sys_clk);
      q_pop = 2'h0;
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      {reset, clk_en, async_ready_select_n} = 3'h7;
      {hold_req_pin, req_valid, xfer_valid, stop_decoded, prot_mode, exec_valid} = 6'h00;
      {sync_ready_select_n, q_pop, waits} = 5'h00;
      {xfer_target, exec_addr, exp_ptr} = 72'h0;
      code_limit = 24'hFFFFFF;
      req_in = lbr_pkg::LBR_REQ_RESET;
      i = $urandom(32'h5247);
      repeat (13) @(negedge sys_clk);
      check(24'({pins_oe, lock_n, bus_grant_out, queue_level}), 24'h10);
      reset = 1'b0;
      // Other master stays off the bus long after reset
      wait_check_level(3'h6);
      for (i = 0; i < 12; i++)
         do_op(1'($urandom), 1'($urandom), 1'b0, 1'b0, 1'b0, 2'($urandom), 1'($urandom));
      do_op(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0);
      do_op(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0);
      do_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0);
      do_op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b1);
      fork
         begin
            repeat (4) @(negedge sys_clk);
            hold_req_pin = 1'b1;
         end
         do_op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 1'b0);
      join
      check(24'(bus_grant_out), 24'h0);
      i = 0;
      while (bus_grant_out !== 1'b1 && i < 8)
      begin
         @(negedge sys_clk);
         i++;
      end
      check(24'(i > 0 && i < 3), 24'h1);
      fork
         begin
            repeat (10)
            begin
               check(24'({bus_grant_out, pins_oe, data_oe, req_taken}), 24'h8);
               @(negedge sys_clk);
            end
            hold_req_pin = 1'b0;
         end
         do_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1);
      join
      @(negedge sys_clk);
      xfer_target = 24'h000101;
      exp_ptr = 24'h000101;
      xfer_valid = 1'b1;
      @(negedge sys_clk);
      xfer_valid = 1'b0;
      wait_check_level(3'h5);
      pop2(1);
      wait_check_level(3'h5);
      stop_decoded = 1'b1;
      pop2(2);
      stop_decoded = 1'b0;
      wait_check_level(3'h1);
      @(negedge sys_clk);
      {prot_mode, code_limit, xfer_target, exp_ptr} = {1'b1, 24'h204, 24'h200, 24'h200};
      xfer_valid = 1'b1;
      @(negedge sys_clk);
      xfer_valid = 1'b0;
      wait_check_level(3'h5);
      pop2(1);
      wait_check_level(3'h3);
      // Clock enable low must freeze the queue against pops
      {clk_en, q_pop} = 3'h2;
      repeat (4) @(negedge sys_clk);
      check(24'(queue_level), 24'h3);
      {clk_en, q_pop} = 3'h4;
      {exec_valid, exec_addr} = {1'b1, 24'h205};
      @(negedge sys_clk);
      check(24'(exc13), 24'h1);
      exec_addr = 24'h204;
      @(negedge sys_clk);
      check(24'(exc13), 24'h0);
      exec_valid = 1'b0;
      close_out();
   end
endmodule // testbench
